// *** rtl/fes_cyc.sv ***
`timescale 1ns/100ps
`default_nettype none
module fes_cyc (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // request
  input  wire logic                       start,
  input  wire logic                       wr,
  input  wire logic [fes_pkg::ADDR_W-1:0] addr,
  input  wire logic [fes_pkg::DATA_W-1:0] wdata,
  output logic                            done,
  output logic                            we_rise,
  output logic      [fes_pkg::DATA_W-1:0] rdata,
  // flash pins
  output logic      [fes_pkg::ADDR_W-1:0] fl_addr,
  input  wire logic [fes_pkg::DATA_W-1:0] fl_dq_i,
  output logic      [fes_pkg::DATA_W-1:0] fl_dq_o,
  output logic                            fl_dq_oe,
  output logic                            fl_ce_b,
  output logic                            fl_oe_b,
  output logic                            fl_we_b
);
  import fes_pkg::*;

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_ACT = 2'b11, CY_HOLD = 2'b10
  } fes_cy_type;

  fes_cy_type cy_q;
  logic [7:0] cnt_q;
  logic       wr_q;

  // ==========================================================
  // one bus cycle: setup, strobe low, strobe high recovery
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cy_q <= CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done <= 1'b0;
      we_rise <= 1'b0;
      rdata <= '0;
      fl_addr <= '0;
      fl_dq_o <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_b <= 1'b1;
      fl_oe_b <= 1'b1;
      fl_we_b <= 1'b1;
    end else begin
      done <= 1'b0;
      we_rise <= 1'b0;
      unique case (cy_q)
        CY_IDLE: if (start) begin
          fl_addr <= addr;
          fl_dq_o <= wdata;
          fl_dq_oe <= wr;
          fl_ce_b <= 1'b0;
          wr_q <= wr;
          cy_q <= CY_SETUP;
        end
        CY_SETUP: begin
          fl_we_b <= !wr_q;
          fl_oe_b <= wr_q;
          cnt_q <= wr_q ? 8'(WP_CYC - 1) : 8'(ACC_CYC - 1);
          cy_q <= CY_ACT;
        end
        CY_ACT: if (cnt_q == 8'h00) begin
          // data latches in the flash on this rising edge
          fl_we_b <= 1'b1;
          fl_oe_b <= 1'b1;
          we_rise <= wr_q;
          if (!wr_q) rdata <= fl_dq_i;
          cnt_q <= 8'(WPH_CYC - 1);
          cy_q <= CY_HOLD;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        CY_HOLD: if (cnt_q == 8'h00) begin
          fl_ce_b <= 1'b1;
          fl_dq_oe <= 1'b0;
          done <= 1'b1;
          cy_q <= CY_IDLE;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      endcase
    end
  end

  // ==========================================================
  AST_WE_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(fl_we_b) |-> !fl_we_b [*8] ##1 !fl_we_b ##1 fl_we_b)
    else $error("write strobe width wrong");
endmodule // fes_cyc
`default_nettype wire

// *** rtl/fes_host.sv ***
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - program resume at any address; extra resumes ignored; suspend again later.
// - whole-array erase is six writes: unlock, setup, unlock, erase code.
// - whole-array erase ignores commands; hardware reset aborts, then reissue.
// - sector erase is six writes ending with sector address and code.
// - 50 us window for extra sector pairs, each within 50 us.
// - running sector erase takes only erase suspend; hardware reset aborts.
// - erase resume continues; extra resumes ignored; suspend again later.
module fes_host #(
  parameter int WIN_CYC = fes_pkg::WIN_CYC_DEF,
  parameter int SUSP_CYC = fes_pkg::SUSP_CYC_DEF
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // flash pins
  output logic      [fes_pkg::ADDR_W-1:0] fl_addr,
  input  wire logic [fes_pkg::DATA_W-1:0] fl_dq_i,
  output logic      [fes_pkg::DATA_W-1:0] fl_dq_o,
  output logic                            fl_dq_oe,
  output logic                            fl_ce_b,
  output logic                            fl_oe_b,
  output logic                            fl_we_b,
  output logic                            fl_reset_b
);
  import fes_pkg::*;

  fes_state_type state_q;
  fes_mode_type  mode_q;
  logic [3:0]        kind_q;
  logic [2:0]        step_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] rd_q;
  logic              err_q, dq3_q, tog_q, psusp_q, first6_q;

  // ==========================================================
  // sequence tables
  function automatic logic [2:0] seq_last(input logic [3:0] k);
    seq_last = (k == C_CHIP || k == C_SECT) ? 3'd5 :
               (k == C_POLL) ? 3'd1 : 3'd0;
  endfunction

  function automatic logic [37:0] seq_word(input logic [3:0] k,
      input logic [2:0] s, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] sa;
    sa = {a[ADDR_W-1:SA_LSB], {SA_LSB{1'b0}}};
    seq_word = {a, 16'h0000};
    if (k == C_CHIP || k == C_SECT) begin
      unique case (s)
        3'd0, 3'd3: seq_word = {UNL_A1, D_UNL1};
        3'd1, 3'd4: seq_word = {UNL_A2, D_UNL2};
        3'd2: seq_word = {UNL_A1, D_SETUP};
        default: seq_word = (k == C_CHIP) ? {UNL_A1, D_CHIP} : {sa, D_SECT};
      endcase
    end else if (k == C_ADD) begin
      seq_word = {sa, D_SECT};
    end else if (k == C_ESUSP || k == C_PSUSP) begin
      seq_word = {a, D_SUSP};
    end else if (k == C_ERES || k == C_PRES) begin
      seq_word = {a, D_RES};
    end else if (k == C_ARST) begin
      seq_word = {a, D_ARST};
    end
  endfunction

  // ==========================================================
  // timers
  logic              win_start, win_stop, win_run, win_done;
  logic [TMR_W-1:0]  win_cnt;
  logic              st_start, st_done;
  logic [TMR_W-1:0]  st_load;
  logic              cyc_start, cyc_done, cyc_rise;
  logic [DATA_W-1:0] cyc_rdata;

  fes_timer u_win (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(win_start), .stop(win_stop),
    .load(TMR_W'(WIN_CYC)), .cnt_q(win_cnt), .run_q(win_run),
    .done_q(win_done)
  );

  fes_timer u_settle (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(st_start), .stop(1'b0),
    .load(st_load), .cnt_q(), .run_q(), .done_q(st_done)
  );

  // ==========================================================
  // command acceptance
  wire [3:0] cmd = reg_wdata[3:0];
  wire cmd_wr = reg_wr && reg_addr == REG_CMD;
  wire win_ok = win_run && win_cnt > TMR_W'(WIN_MARGIN);
  wire in_win = mode_q == M_WINDOW;
  wire erasing = mode_q == M_ERASE;
  wire ready = mode_q == M_READY;
  wire esusp = mode_q == M_ESUSP;
  // no further sector adds once the window is gone or erase runs
  wire ok_chip = (cmd == C_CHIP || cmd == C_SECT) && ready && !psusp_q;
  wire ok_add = cmd == C_ADD && in_win && win_ok;
  wire ok_esusp = cmd == C_ESUSP && (in_win || erasing);
  wire ok_eres = cmd == C_ERES && esusp && !psusp_q;
  wire ok_psusp = cmd == C_PSUSP && !psusp_q && (ready || esusp);
  wire ok_pres = cmd == C_PRES && psusp_q;
  wire ok_rd = cmd == C_READ || cmd == C_POLL || cmd == C_HWRST;
  wire ok_arst = cmd == C_ARST && (ready || esusp);
  wire cmd_ok = ok_chip || ok_add || ok_esusp || ok_eres || ok_psusp ||
                ok_pres || ok_rd || ok_arst;
  wire acc = cmd_wr && state_q == S_IDLE && cmd_ok;
  wire refuse = cmd_wr && !acc;

  wire is_rd = kind_q == C_READ || kind_q == C_POLL;
  wire [37:0] word = seq_word(kind_q, step_q, addr_q);
  wire fin = state_q == S_BUSY && cyc_done && step_q == seq_last(kind_q);
  wire need_settle = fin && (kind_q == C_PSUSP ||
                     (kind_q == C_ESUSP && erasing));
  wire poll_tog = cyc_rdata[DQ6_POS] != first6_q;

  assign cyc_start = state_q == S_ISSUE;
  assign win_start = cyc_rise && step_q == seq_last(kind_q) &&
                     (kind_q == C_SECT || kind_q == C_ADD);
  assign win_stop = fin && kind_q == C_ESUSP;
  assign st_start = need_settle || (acc && cmd == C_HWRST);
  assign st_load = need_settle ? TMR_W'(SUSP_CYC) : TMR_W'(RP_CYC);

  fes_cyc u_cyc (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(cyc_start), .wr(!is_rd),
    .addr(word[37:16]), .wdata(word[15:0]), .done(cyc_done),
    .we_rise(cyc_rise), .rdata(cyc_rdata), .fl_addr(fl_addr),
    .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_ce_b(fl_ce_b), .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      kind_q <= C_NONE;
      step_q <= 3'd0;
      fl_reset_b <= 1'b1;
    end else begin
      unique case (state_q)
        S_IDLE: if (acc) begin
          kind_q <= cmd;
          step_q <= 3'd0;
          fl_reset_b <= cmd != C_HWRST;
          state_q <= (cmd == C_HWRST) ? S_RST : S_ISSUE;
        end
        S_ISSUE: state_q <= S_BUSY;
        S_BUSY: if (fin) begin
          state_q <= need_settle ? S_SETTLE : S_IDLE;
        end else if (cyc_done) begin
          step_q <= step_q + 3'd1;
          state_q <= S_ISSUE;
        end
        S_SETTLE: if (st_done) state_q <= S_IDLE;
        S_RST: if (st_done) begin
          fl_reset_b <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // host view of the flash mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= M_READY;
      psusp_q <= 1'b0;
    end else if (state_q == S_RST) begin
      mode_q <= M_READY;
      psusp_q <= 1'b0;
    end else if (fin) begin
      unique case (kind_q)
        C_CHIP: mode_q <= M_CHIP;
        C_SECT, C_ADD: mode_q <= M_WINDOW;
        C_ESUSP: mode_q <= M_ESUSP;
        C_ERES: mode_q <= M_ERASE;
        C_PSUSP: psusp_q <= 1'b1;
        C_PRES: psusp_q <= 1'b0;
        C_POLL: if (!poll_tog && (erasing || mode_q == M_CHIP)) begin
          mode_q <= M_READY;
        end else if (in_win && cyc_rdata[DQ3_POS]) begin
          mode_q <= M_ERASE;
        end
        default: mode_q <= mode_q;
      endcase
    end else if (win_done && in_win) begin
      mode_q <= M_ERASE;
    end
  end

  // ==========================================================
  // read data, poll status, error flag
  wire stat_wr = reg_wr && reg_addr == REG_STAT;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= '0;
      first6_q <= 1'b0;
      dq3_q <= 1'b0;
      tog_q <= 1'b0;
      err_q <= 1'b0;
      addr_q <= '0;
    end else begin
      if (reg_wr && reg_addr == REG_ADDR) addr_q <= reg_wdata[ADDR_W-1:0];
      if (state_q == S_BUSY && cyc_done && is_rd) begin
        rd_q <= cyc_rdata;
        dq3_q <= cyc_rdata[DQ3_POS];
        if (step_q == 3'd0) first6_q <= cyc_rdata[DQ6_POS];
        if (kind_q == C_POLL && step_q == 3'd1) tog_q <= poll_tog;
      end
      // a refusal in the clearing cycle still sets the flag
      if (refuse) err_q <= 1'b1;
      else if (stat_wr && reg_wdata[ST_ERR]) err_q <= 1'b0;
    end
  end

  wire [31:0] stat_word = {24'h000000, psusp_q, tog_q, dq3_q, err_q,
                           state_q != S_IDLE, mode_q};
  wire [31:0] rd_mux = (reg_addr == REG_ADDR) ? {10'h000, addr_q} :
                       (reg_addr == REG_RDATA) ? {16'h0000, rd_q} :
                       (reg_addr == REG_STAT) ? stat_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 32'h00000000;
    else reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
  end

  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_UNLOCK: assert property (cyc_start && step_q == 3'd0 &&
      (kind_q == C_CHIP || kind_q == C_SECT) |=>
      fl_addr[11:0] == 12'h555 && fl_dq_o[7:0] == 8'haa)
    else $error("first unlock cycle wrong");
  AST_SECTOR: assert property (cyc_start && kind_q == C_SECT &&
      step_q == 3'd5 |=> fl_addr[SA_LSB-1:0] == '0 &&
      fl_addr[ADDR_W-1:SA_LSB] == addr_q[ADDR_W-1:SA_LSB] &&
      fl_dq_o == D_SECT)
    else $error("sector erase word wrong");
  AST_SIX: assert property ($changed(mode_q) && mode_q == M_CHIP |->
      $past(step_q) == 3'd5 && $past(kind_q) == C_CHIP)
    else $error("chip erase not six writes");
  AST_WIN: assert property (win_start |=> win_run &&
      win_cnt == TMR_W'(WIN_CYC) ##1 win_cnt == TMR_W'(WIN_CYC - 1))
    else $error("window not started at strobe rise");
  AST_EXPIRE: assert property (in_win && win_done && !fin |=>
      mode_q == M_ERASE)
    else $error("window expiry not seen");
  AST_IN_WIN: assert property (acc && in_win |-> cmd == C_ADD ||
      cmd == C_ESUSP || cmd == C_READ || cmd == C_POLL || cmd == C_HWRST)
    else $error("abort command sent in window");
  AST_BUSY_ONLY: assert property (acc && (erasing ||
      mode_q == M_CHIP) |-> cmd == C_READ || cmd == C_POLL ||
      cmd == C_HWRST || (cmd == C_ESUSP && erasing))
    else $error("command sent during erase");
  AST_CHIP_SUSP: assert property (cmd_wr && cmd == C_ESUSP &&
      !(in_win || erasing) |-> !acc)
    else $error("suspend outside sector erase");
  AST_RESUME: assert property (acc && cmd == C_ERES |-> esusp)
    else $error("resume outside suspend");
  AST_HWRST: assert property (acc && cmd == C_HWRST |=>
      !fl_reset_b [*8])
    else $error("reset pulse too short");
  AST_SETTLE: assert property (need_settle |=>
      state_q == S_SETTLE [*8])
    else $error("suspend settle skipped");
  AST_IMM: assert property (fin && kind_q == C_ESUSP && in_win |=>
      mode_q == M_ESUSP && state_q == S_IDLE && !win_run)
    else $error("window suspend not immediate");

  COV_WINDOW: cover property ($changed(mode_q) && mode_q == M_WINDOW);
  COV_SUSP_RES: cover property (fin && kind_q == C_ERES);
  COV_CHIP_DONE: cover property ($past(mode_q) == M_CHIP &&
      mode_q == M_READY);
endmodule // fes_host
`default_nettype wire

// *** rtl/fes_pkg.sv ***
package fes_pkg;

  // ==========================================================
  // flash pin widths and fields
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int SA_LSB = 15;
  localparam int DQ3_POS = 3;
  localparam int DQ6_POS = 6;

  // ==========================================================
  // command cycle patterns
  localparam logic [21:0] UNL_A1 = 22'h000555;
  localparam logic [21:0] UNL_A2 = 22'h0002aa;
  localparam logic [15:0] D_UNL1 = 16'h00aa;
  localparam logic [15:0] D_UNL2 = 16'h0055;
  localparam logic [15:0] D_SETUP = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SECT = 16'h0030;
  localparam logic [15:0] D_SUSP = 16'h00b0;
  localparam logic [15:0] D_RES = 16'h0030;
  localparam logic [15:0] D_ARST = 16'h00f0;

  // ==========================================================
  // register map of the controller
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int ST_BUSY = 3;
  localparam int ST_ERR = 4;
  localparam int ST_DQ3 = 5;
  localparam int ST_TOG = 6;
  localparam int ST_PSUSP = 7;

  // ==========================================================
  // commands, modes, states
  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_CHIP = 4'h1, C_SECT = 4'h2, C_ADD = 4'h3,
    C_ESUSP = 4'h4, C_ERES = 4'h5, C_PSUSP = 4'h6, C_PRES = 4'h7,
    C_READ = 4'h8, C_POLL = 4'h9, C_HWRST = 4'ha, C_ARST = 4'hb
  } fes_cmd_type;

  typedef enum logic [2:0] {
    M_READY = 3'b000, M_WINDOW = 3'b001, M_ERASE = 3'b011,
    M_ESUSP = 3'b010, M_CHIP = 3'b110
  } fes_mode_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ISSUE = 3'b001, S_BUSY = 3'b011,
    S_SETTLE = 3'b010, S_RST = 3'b110
  } fes_state_type;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_WIN_US = 50;
  localparam int T_SUSP_US = 20;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int WIN_CYC_DEF = T_WIN_US * CLK_MHZ;
  localparam int SUSP_CYC_DEF = T_SUSP_US * CLK_MHZ;
  localparam int WIN_MARGIN = 64;
  localparam int TMR_W = 14;

endpackage

// *** rtl/fes_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module fes_timer (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // control
  input  wire logic                      start,
  input  wire logic                      stop,
  input  wire logic [fes_pkg::TMR_W-1:0] load,
  // state
  output logic      [fes_pkg::TMR_W-1:0] cnt_q,
  output logic                           run_q,
  output logic                           done_q
);
  import fes_pkg::*;

  // ==========================================================
  // down counter, start wins over stop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= run_q && cnt_q == TMR_W'(1) && !start && !stop;
      if (start) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (stop || (run_q && cnt_q == TMR_W'(1))) begin
        cnt_q <= '0;
        run_q <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q - TMR_W'(1);
      end
    end
  end
endmodule // fes_timer
`default_nettype wire

// *** verif/fes_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fes_flash_model #(
  parameter int WIN_NS = 800,
  parameter int ERS_NS = 8000
) (
  // flash pins
  input  wire logic [21:0] fl_addr,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        fl_ce_b,
  input  wire logic        fl_oe_b,
  input  wire logic        fl_we_b,
  input  wire logic        fl_reset_b
);
  // ====================
  // modes: 0 read, 1 window, 3 erasing, 2 suspended, 6 chip erase
  localparam logic [18:0] SEQ [5] = '{{11'h555, 8'haa}, {11'h2aa, 8'h55},
    {11'h555, 8'h80}, {11'h555, 8'haa}, {11'h2aa, 8'h55}};
  logic    [2:0]  md = 3'h0;
  logic    [6:0]  sa = 7'h0;
  logic    [15:0] rv = 16'h0;
  logic           tog = 1'b0;
  logic           psus = 1'b0;
  int             st = 0;
  realtime        t0 = 0;
  wire logic [18:0] ad = {fl_addr[10:0], dq_in[7:0]};
  always @(posedge fl_we_b or negedge fl_reset_b) begin
    if (!fl_reset_b) begin
      md = 3'h0;
      st = 0;
      psus = 1'b0;
    end else if (!fl_ce_b) begin
      if (md == 3'h1 && ad[7:0] == 8'h30) t0 = $realtime;
      else if (md[0] && ad[7:0] == 8'hb0) md = 3'h2;
      else if (md == 3'h1) md = 3'h0;
      else if ((md == 3'h0 || md == 3'h2) && ad[7:0] == 8'hb0)
        psus = 1'b1;
      else if (psus && ad[7:0] == 8'h30) psus = 1'b0;
      else if (md == 3'h2 && ad[7:0] == 8'h30) begin
        md = 3'h3;
        t0 = $realtime;
      end else if (md == 3'h0) begin
        if (st == 5 && ad[7:0] == 8'h10) md = 3'h6;
        if (st == 5 && ad[7:0] == 8'h30) md = 3'h1;
        if (st == 5) sa = fl_addr[21:15];
        t0 = $realtime;
        st = (st < 5 && ad == SEQ[st]) ? st + 1 : 0;
      end
    end
  end
  // slow on purpose: erase runs many polls long
  always #4 begin
    if (md == 3'h1 && $realtime - t0 >= WIN_NS) begin
      md = 3'h3;
      t0 = $realtime;
    end
    if ((md == 3'h3 || md == 3'h6) && $realtime - t0 >= ERS_NS)
      md = 3'h0;
  end
  always @(negedge fl_oe_b) begin
    tog = ~tog;
    if (md == 3'h0 || (md == 3'h2 && fl_addr[21:15] != sa))
      rv = fl_addr[15:0] ^ 16'h5a5a;
    else
      rv = {8'h0, md != 3'h2, tog & md != 3'h2, 2'h0, md[1],
            3'h0};
  end
  // released bus shows the inverse so a stale value never passes
  assign dq_out = (!fl_ce_b && !fl_oe_b) ? rv : ~rv;
endmodule  // fes_flash_model
`default_nettype wire

// *** verif/tb_fes_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_fes_host;
  import fes_pkg::*;
  // ====================
  // signals
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, v;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i, mdl_dq;
  logic        fl_dq_oe, fl_ce_b, fl_oe_b, fl_we_b, fl_reset_b;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // rows: command, address, status masked to mode, busy, err, psusp
  localparam logic [33:0] ROW [17] = '{
    {4'h6, 22'h0, 8'h80}, {4'h7, 22'h0, 8'h00},
    {4'h7, 22'h0, 8'h10}, {4'h2, 22'h018000, 8'h01},
    {4'h3, 22'h020000, 8'h01}, {4'h4, 22'h0, 8'h02},
    {4'h5, 22'h0, 8'h03}, {4'h5, 22'h0, 8'h13},
    {4'h1, 22'h0, 8'h13}, {4'h4, 22'h0, 8'h02},
    {4'h6, 22'h0, 8'h82}, {4'h7, 22'h0, 8'h02},
    {4'h5, 22'h0, 8'h03}, {4'h1, 22'h0, 8'h06},
    {4'h4, 22'h0, 8'h16}, {4'ha, 22'h0, 8'h00},
    {4'h8, 22'h000123, 8'h00}};
  always #2 clk_sys = ~clk_sys;
  assign fl_dq_i = fl_dq_oe ? fl_dq_o : mdl_dq;
  fes_host #(.WIN_CYC(200), .SUSP_CYC(20)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_b(fl_ce_b),
    .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b), .fl_reset_b(fl_reset_b));
  fes_flash_model #(.WIN_NS(800), .ERS_NS(8000)) flash (
    .fl_addr(fl_addr), .dq_in(fl_dq_o), .dq_out(mdl_dq),
    .fl_ce_b(fl_ce_b), .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b),
    .fl_reset_b(fl_reset_b));
  // ====================
  // tasks
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
    @(posedge clk_sys);
  endtask
  // clears err first so each status check sees only this command
  task automatic run_cmd(input logic [3:0] c, input logic [21:0] a);
    int i;
    wr(REG_STAT, 32'h10);
    wr(REG_ADDR, {10'h0, a});
    wr(REG_CMD, {28'h0, c});
    i = 0;
    do begin
      rd(REG_STAT);
      i++;
    end while (v[ST_BUSY] !== 1'b0 && i < 2000);
    if (v[ST_BUSY] !== 1'b0) begin
      chk("busy wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  // ====================
  // sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk("idle pins", 32'h1e,
        {fl_ce_b, fl_oe_b, fl_we_b, fl_reset_b, fl_dq_oe});
    rd(REG_STAT);
    chk("status reset", 32'h0, v);
    rd(8'h20);
    chk("unmapped", 32'h0, v);
    wr(REG_ADDR, 32'hffffffff);
    rd(REG_ADDR);
    chk("address reg", 32'h3fffff, v);
    $display("reset test done");
    for (int r = 0; r < 17; r++) begin
      for (int i = 0; i < 200 && r == 13 && v[2:0] !== 3'h0; i++)
        run_cmd(4'h9, 22'h018000);
      if (r == 13) chk("erase end", 32'h0, {29'h0, v[2:0]});
      run_cmd(ROW[r][33:30], ROW[r][29:8]);
      chk("status", {24'h0, ROW[r][7:0]}, v & 32'h9f);
      $display("row %0d done", r);
    end
    rd(REG_RDATA);
    chk("array read", 32'h5b79, v);
    run_cmd(4'h2, 22'h3f8000);
    repeat (260) @(posedge clk_sys);
    run_cmd(4'h8, 22'h000010);
    chk("timer bit", 32'h23, v & 32'h27);
    run_cmd(4'h9, 22'h3f8000);
    chk("erase toggle", 32'h63, v & 32'h67);
    run_cmd(4'h4, 22'h0);
    run_cmd(4'h8, 22'h3f8000);
    rd(REG_RDATA);
    chk("suspended read", 32'h8, v);
    run_cmd(4'h8, 22'h000010);
    rd(REG_RDATA);
    chk("other sector", 32'h5a4a, v);
    $display("suspend read test done");
    run_cmd(4'hb, 22'h0);
    chk("array reset", 32'h2, v & 32'h9f);
    $display("array reset test done");
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(REG_STAT);
    chk("status after reset", 32'h0, v);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule  // tb_fes_host
`default_nettype wire
